// ---- verilog/umlb_pkg.sv ----
// Package: constants for the serial channel with modem lines and loopback
package umlb_pkg;
	localparam int FIFO_DEPTH = 16;
	localparam int PTR_W = 4;
	localparam int CNT_W = 5;
	localparam int DATA_W = 8;
	localparam int CLK_HZ = 10000000;
	localparam int BAUD_DIV_W = 16;
	// Oversampling: sixteen ticks per serial bit
	localparam int OVS = 16;
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] OVS_MID = 4'h7;
	// Receive thresholds selected by a two-bit code
	localparam logic [CNT_W-1:0] TRIG_1 = 5'h01;
	localparam logic [CNT_W-1:0] TRIG_4 = 5'h04;
	localparam logic [CNT_W-1:0] TRIG_8 = 5'h08;
	localparam logic [CNT_W-1:0] TRIG_14 = 5'h0E;
	localparam logic [CNT_W-1:0] ONE_ENTRY = 5'h01;
	// Line control field layout
	localparam int LC_WLEN_LO = 0;
	localparam int LC_STOP = 2;
	localparam int LC_PEN = 3;
	localparam int LC_EVEN = 4;
	// Modem control field layout
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_OUT1 = 2;
	localparam int MC_OUT2 = 3;
	localparam int MC_LOOP = 4;
	// Modem status field layout
	localparam int MS_DCTS = 0;
	localparam int MS_DDSR = 1;
	localparam int MS_TERI = 2;
	localparam int MS_DDCD = 3;
	localparam int MS_CTS = 4;
	localparam int MS_DSR = 5;
	localparam int MS_RI = 6;
	localparam int MS_DCD = 7;
	typedef enum logic [4:0] {
		UMLB_IDLE = 5'h01,
		UMLB_START = 5'h02,
		UMLB_DATA = 5'h04,
		UMLB_PAR = 5'h08,
		UMLB_STOP = 5'h10
	} umlb_state_t;
endpackage : umlb_pkg

// ---- verilog/umlb_fifo.sv ----
// Sixteen-entry byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
module umlb_fifo
	import umlb_pkg::*;
#(
	parameter int W = DATA_W
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [CNT_W-1:0] count
);
	logic [W-1:0] mem_q [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_q;
	logic [PTR_W-1:0] rd_q;
	logic [CNT_W-1:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != CNT_W'(FIFO_DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign count = cnt_q;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst || flush)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_q <= wr_q + 4'h1;
			end
			if (pop)
			begin
				rd_q <= rd_q + 4'h1;
			end
			if (push && !pop)
			begin
				cnt_q <= cnt_q + ONE_ENTRY;
			end
			else if (pop && !push)
			begin
				cnt_q <= cnt_q - ONE_ENTRY;
			end
		end
	end
endmodule : umlb_fifo

// ---- verilog/umlb_channel.sv ----
// One serial channel: modem lines, framing with parity, FIFOs and local loopback
`timescale 1ns/1ps
module umlb_channel
	import umlb_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [7:0] MODEM_CONTROL_REG,
	input wire logic [4:0] LINE_CONTROL,
	input wire logic [1:0] RX_TRIGGER_SEL,
	input wire logic FIFO_ENABLE,
	input wire logic TX_ENABLE,
	input wire logic [BAUD_DIV_W-1:0] BAUD_DIV,
	input wire logic TX_WR,
	input wire logic [DATA_W-1:0] TX_DATA,
	input wire logic RX_RD,
	input wire logic MSR_RD,
	input wire logic serial_in,
	input wire logic clear_send_in_n,
	input wire logic set_ready_in_n,
	input wire logic ring_detect_in_n,
	input wire logic carrier_in_n,
	output logic serial_out,
	output logic terminal_ready_out_n,
	output logic request_send_out_n,
	output logic [7:0] MODEM_STATUS_REG,
	output logic [DATA_W-1:0] RX_DATA,
	output logic RX_DATA_READY,
	output logic RX_PARITY_ERR,
	output logic RX_FRAME_ERR,
	output logic RX_OVERRUN,
	output logic TX_SPACE,
	output logic RX_TRIGGER_IRQ,
	output logic MODEM_IRQ
);
	// ----------------------------------------
	// Input synchronisers and modem status
	// ----------------------------------------
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic loop;
	logic [3:0] mdm_in;
	logic [3:0] mdm_prev_q;
	logic rx_line;
	logic tx_line_q;

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			sync1_q <= 5'h1F;
			sync2_q <= 5'h1F;
		end
		else
		begin
			sync1_q <= {carrier_in_n, ring_detect_in_n, set_ready_in_n, clear_send_in_n, serial_in};
			sync2_q <= sync1_q;
		end
	end

	assign loop = MODEM_CONTROL_REG[MC_LOOP];
	// Active-high view {dcd, ri, dsr, cts}; in loopback from our own controls
	assign mdm_in = loop ? {MODEM_CONTROL_REG[MC_OUT2], MODEM_CONTROL_REG[MC_OUT1], MODEM_CONTROL_REG[MC_DTR],
		MODEM_CONTROL_REG[MC_RTS]} : ~sync2_q[4:1];
	assign rx_line = loop ? tx_line_q : sync2_q[0];

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			mdm_prev_q <= 4'h0;
			MODEM_STATUS_REG <= 8'h00;
			MODEM_IRQ <= 1'b0;
		end
		else
		begin
			mdm_prev_q <= mdm_in;
			// Status bits 4..7 follow the lines; set-ready and clear-to-send are status only
			MODEM_STATUS_REG[MS_DCD:MS_CTS] <= mdm_in;
			// Delta bits are sticky; a new change wins over the read that clears them
			MODEM_STATUS_REG[MS_DCTS] <= (mdm_in[0] != mdm_prev_q[0]) || (MODEM_STATUS_REG[MS_DCTS] && !MSR_RD);
			MODEM_STATUS_REG[MS_DDSR] <= (mdm_in[1] != mdm_prev_q[1]) || (MODEM_STATUS_REG[MS_DDSR] && !MSR_RD);
			// Ring pin rising means ring indication going inactive
			MODEM_STATUS_REG[MS_TERI] <= (!mdm_in[2] && mdm_prev_q[2])
				|| (MODEM_STATUS_REG[MS_TERI] && !MSR_RD);
			MODEM_STATUS_REG[MS_DDCD] <= (mdm_in[3] != mdm_prev_q[3]) || (MODEM_STATUS_REG[MS_DDCD] && !MSR_RD);
			MODEM_IRQ <= (mdm_in != mdm_prev_q) || (|MODEM_STATUS_REG[MS_DDCD:MS_DCTS] && !MSR_RD);
		end
	end

	// ----------------------------------------
	// Modem control outputs
	// ----------------------------------------
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			terminal_ready_out_n <= 1'b1;
			request_send_out_n <= 1'b1;
		end
		else
		begin
			terminal_ready_out_n <= loop || !MODEM_CONTROL_REG[MC_DTR];
			request_send_out_n <= loop || !MODEM_CONTROL_REG[MC_RTS];
		end
	end

	// ----------------------------------------
	// Baud tick and frame helpers
	// ----------------------------------------
	logic [BAUD_DIV_W-1:0] baud_cnt_q;
	logic tick_q;

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			baud_cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else if (baud_cnt_q >= BAUD_DIV - 16'h0001 || BAUD_DIV == '0)
		begin
			baud_cnt_q <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			baud_cnt_q <= baud_cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// Number of data bits minus one (5..8 bits)
	function automatic logic [2:0] last_bit(input logic [1:0] wlen);
		last_bit = 3'h4 + {1'b0, wlen};
	endfunction : last_bit

	// Parity over the valid data bits
	function automatic logic calc_parity(input logic [DATA_W-1:0] d, input logic [1:0] wlen, input logic even);
		logic [DATA_W-1:0] m;
		m = 8'hFF >> (3'h3 - {1'b0, wlen});
		calc_parity = ^(d & m) ^ !even;
	endfunction : calc_parity

	// ----------------------------------------
	// FIFOs
	// ----------------------------------------
	logic tx_fifo_valid;
	logic tx_fifo_ready;
	logic [DATA_W-1:0] tx_fifo_data;
	logic tx_take;
	logic [CNT_W-1:0] tx_count;
	logic rx_push;
	logic rx_fifo_ready;
	logic rx_fifo_valid;
	logic [DATA_W-1:0] rx_fifo_data;
	logic [CNT_W-1:0] rx_count;
	logic [DATA_W-1:0] rx_word_q;
	logic fifo_mode_q;
	logic room;
	logic [CNT_W-1:0] trig;

	// Toggling FIFO mode flushes both buffers
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			fifo_mode_q <= 1'b0;
		end
		else
		begin
			fifo_mode_q <= FIFO_ENABLE;
		end
	end

	// Holding-register mode takes one byte only
	assign room = fifo_mode_q ? tx_fifo_ready : (tx_count == '0);

	umlb_fifo u_tx_fifo (
		.clk(CLK),
		.rst(RST),
		.flush(fifo_mode_q != FIFO_ENABLE),
		.in_valid(TX_WR && room),
		.in_ready(tx_fifo_ready),
		.in_data(TX_DATA),
		.out_valid(tx_fifo_valid),
		.out_ready(tx_take),
		.out_data(tx_fifo_data),
		.count(tx_count)
	);

	umlb_fifo u_rx_fifo (
		.clk(CLK),
		.rst(RST),
		.flush(fifo_mode_q != FIFO_ENABLE),
		.in_valid(rx_push),
		.in_ready(rx_fifo_ready),
		.in_data(rx_word_q),
		.out_valid(rx_fifo_valid),
		.out_ready(RX_RD),
		.out_data(rx_fifo_data),
		.count(rx_count)
	);

	always_comb
	begin
		if (!fifo_mode_q)
		begin
			trig = TRIG_1;
		end
		else if (RX_TRIGGER_SEL == 2'h0)
		begin
			trig = TRIG_1;
		end
		else if (RX_TRIGGER_SEL == 2'h1)
		begin
			trig = TRIG_4;
		end
		else if (RX_TRIGGER_SEL == 2'h2)
		begin
			trig = TRIG_8;
		end
		else
		begin
			trig = TRIG_14;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			RX_DATA <= '0;
			RX_DATA_READY <= 1'b0;
			TX_SPACE <= 1'b1;
			RX_TRIGGER_IRQ <= 1'b0;
		end
		else
		begin
			RX_DATA <= rx_fifo_data;
			RX_DATA_READY <= rx_fifo_valid;
			TX_SPACE <= room;
			RX_TRIGGER_IRQ <= (rx_count >= trig);
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	umlb_state_t tx_st_q;
	logic [3:0] tx_ovs_q;
	logic [2:0] tx_bit_q;
	logic [DATA_W-1:0] tx_sh_q;
	logic tx_par_q;
	logic [4:0] lc_q;

	assign tx_take = (tx_st_q == UMLB_IDLE) && TX_ENABLE && tick_q;

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			tx_st_q <= UMLB_IDLE;
			tx_ovs_q <= 4'h0;
			tx_bit_q <= 3'h0;
			tx_sh_q <= '0;
			tx_par_q <= 1'b0;
			tx_line_q <= 1'b1;
			lc_q <= 5'h00;
		end
		else if (tick_q || tx_take)
		begin
			tx_ovs_q <= (tx_st_q == UMLB_IDLE) ? 4'h0 : tx_ovs_q + 4'h1;
			case (tx_st_q)
				UMLB_IDLE:
				begin
					tx_line_q <= 1'b1;
					if (tx_fifo_valid && TX_ENABLE)
					begin
						lc_q <= LINE_CONTROL;
						tx_sh_q <= tx_fifo_data;
						tx_par_q <= calc_parity(tx_fifo_data, LINE_CONTROL[LC_WLEN_LO +: 2], LINE_CONTROL[LC_EVEN]);
						tx_line_q <= 1'b0;
						tx_st_q <= UMLB_START;
					end
				end
				UMLB_START:
				begin
					if (tx_ovs_q == OVS_LAST)
					begin
						tx_line_q <= tx_sh_q[0];
						tx_sh_q <= tx_sh_q >> 1;
						tx_bit_q <= 3'h0;
						tx_st_q <= UMLB_DATA;
					end
				end
				UMLB_DATA:
				begin
					if (tx_ovs_q == OVS_LAST)
					begin
						if (tx_bit_q == last_bit(lc_q[LC_WLEN_LO +: 2]))
						begin
							tx_line_q <= lc_q[LC_PEN] ? tx_par_q : 1'b1;
							tx_st_q <= lc_q[LC_PEN] ? UMLB_PAR : UMLB_STOP;
							tx_bit_q <= 3'h0;
						end
						else
						begin
							tx_line_q <= tx_sh_q[0];
							tx_sh_q <= tx_sh_q >> 1;
							tx_bit_q <= tx_bit_q + 3'h1;
						end
					end
				end
				UMLB_PAR:
				begin
					if (tx_ovs_q == OVS_LAST)
					begin
						tx_line_q <= 1'b1;
						tx_st_q <= UMLB_STOP;
					end
				end
				UMLB_STOP:
				begin
					// Two stop bits when selected; half-bit variant not offered
					if (tx_ovs_q == OVS_LAST)
					begin
						if (lc_q[LC_STOP] && tx_bit_q == 3'h0)
						begin
							tx_bit_q <= 3'h1;
						end
						else
						begin
							tx_st_q <= UMLB_IDLE;
						end
					end
				end
				default:
				begin
					tx_st_q <= UMLB_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			serial_out <= 1'b1;
		end
		else
		begin
			// A disabled transmitter may be cut mid-frame; the pin still returns to mark at once
			serial_out <= (loop || !TX_ENABLE) ? 1'b1 : tx_line_q;
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	umlb_state_t rx_st_q;
	logic [3:0] rx_ovs_q;
	logic [2:0] rx_bit_q;
	logic rx_par_ok_q;

	// Stop bit is sampled a full bit after the last data or parity sample, i.e. at its centre
	assign rx_push = (rx_st_q == UMLB_STOP) && tick_q && rx_ovs_q == OVS_LAST && rx_fifo_ready
		&& (fifo_mode_q || rx_count == '0);

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			rx_st_q <= UMLB_IDLE;
			rx_ovs_q <= 4'h0;
			rx_bit_q <= 3'h0;
			rx_word_q <= '0;
			rx_par_ok_q <= 1'b1;
			RX_PARITY_ERR <= 1'b0;
			RX_FRAME_ERR <= 1'b0;
			RX_OVERRUN <= 1'b0;
		end
		else if (tick_q)
		begin
			rx_ovs_q <= rx_ovs_q + 4'h1;
			case (rx_st_q)
				UMLB_IDLE:
				begin
					rx_ovs_q <= 4'h0;
					if (!rx_line)
					begin
						rx_st_q <= UMLB_START;
					end
				end
				UMLB_START:
				begin
					// Line back high at mid start bit: false start, ignore
					if (rx_ovs_q == OVS_MID)
					begin
						rx_st_q <= rx_line ? UMLB_IDLE : UMLB_DATA;
						rx_ovs_q <= 4'h0;
						rx_bit_q <= 3'h0;
						rx_word_q <= '0;
					end
				end
				UMLB_DATA:
				begin
					if (rx_ovs_q == OVS_LAST)
					begin
						rx_word_q[rx_bit_q] <= rx_line;
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == last_bit(LINE_CONTROL[LC_WLEN_LO +: 2]))
						begin
							rx_st_q <= LINE_CONTROL[LC_PEN] ? UMLB_PAR : UMLB_STOP;
							rx_par_ok_q <= 1'b1;
						end
					end
				end
				UMLB_PAR:
				begin
					if (rx_ovs_q == OVS_LAST)
					begin
						rx_par_ok_q <= rx_line == calc_parity(rx_word_q, LINE_CONTROL[LC_WLEN_LO +: 2],
							LINE_CONTROL[LC_EVEN]);
						rx_st_q <= UMLB_STOP;
						rx_ovs_q <= 4'h0;
					end
				end
				UMLB_STOP:
				begin
					if (rx_st_q == UMLB_STOP && rx_ovs_q == OVS_LAST)
					begin
						RX_PARITY_ERR <= !rx_par_ok_q;
						RX_FRAME_ERR <= !rx_line;
						RX_OVERRUN <= !(rx_fifo_ready && (fifo_mode_q || rx_count == '0));
						rx_st_q <= UMLB_IDLE;
					end
				end
				default:
				begin
					rx_st_q <= UMLB_IDLE;
				end
			endcase
		end
	end
endmodule : umlb_channel

// ---- dv/umlb_modem.sv ----
// Modem model: drives modem lines and serial data, captures frames
`timescale 1ns/1ps
module umlb_modem
#(
	parameter int BIT_CYC = 16
)
(
	input wire logic CLK,
	input wire logic serial_out,
	output logic serial_in,
	output logic clear_send_in_n,
	output logic set_ready_in_n,
	output logic ring_detect_in_n,
	output logic carrier_in_n
);
	// Line at mark and all modem lines inactive until told otherwise
	initial {serial_in, clear_send_in_n, set_ready_in_n, ring_detect_in_n, carrier_in_n} = 5'h1F;
	task automatic set_lines(input logic [4:0] v);
		@(negedge CLK);
		{serial_in, clear_send_in_n, set_ready_in_n, ring_detect_in_n, carrier_in_n} = v;
	endtask : set_lines
	task automatic send(input logic [7:0] d, input int nb, input logic pen, input logic pb, input int ns);
		@(negedge CLK);
		serial_in = 1'b0;
		repeat (BIT_CYC) @(negedge CLK);
		for (int i = 0; i < nb + pen + ns; i++)
		begin
			serial_in = (i < nb) ? d[i] : (i == nb && pen) ? pb : 1'b1;
			repeat (BIT_CYC) @(negedge CLK);
		end
	endtask : send
	// Samples mid-bit; a missing start bit leaves a one in bit 0
	task automatic recv(input int n, output logic [11:0] f);
		int w;
		f = 12'h000;
		for (w = 0; w < 400 && serial_out !== 1'b0; w++) @(negedge CLK);
		repeat (BIT_CYC / 2) @(negedge CLK);
		for (int i = 0; i < n; i++)
		begin
			f[i] = serial_out;
			repeat (BIT_CYC) @(negedge CLK);
		end
	endtask : recv
endmodule : umlb_modem

// ---- dv/umlb_chk.sv ----
// Checker: port properties of the serial channel
`timescale 1ns/1ps
module umlb_chk
	import umlb_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [7:0] MODEM_CONTROL_REG,
	input wire logic TX_ENABLE,
	input wire logic clear_send_in_n,
	input wire logic ring_detect_in_n,
	input wire logic serial_out,
	input wire logic terminal_ready_out_n,
	input wire logic request_send_out_n,
	input wire logic [7:0] MODEM_STATUS_REG,
	input wire logic RX_DATA_READY,
	input wire logic TX_SPACE,
	input wire logic MODEM_IRQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	sequence loop_held;
		MODEM_CONTROL_REG[MC_LOOP] [*2];
	endsequence
	sequence tx_off;
		!TX_ENABLE [*2];
	endsequence
	// Status goes through a two-stage synchroniser, so allow a few cycles
	a_reset_defaults:
		assert property (disable iff (1'b0) $past(RST) |-> serial_out && terminal_ready_out_n
			&& request_send_out_n && !RX_DATA_READY && TX_SPACE) else $error("outputs not at defaults after reset");
	a_dtr_follows:
		assert property (!$past(RST) |-> terminal_ready_out_n ==
			($past(MODEM_CONTROL_REG[MC_LOOP]) | !$past(MODEM_CONTROL_REG[MC_DTR]))) else $error("dtr wrong");
	a_rts_follows:
		assert property (!$past(RST) |-> request_send_out_n ==
			($past(MODEM_CONTROL_REG[MC_LOOP]) | !$past(MODEM_CONTROL_REG[MC_RTS]))) else $error("rts wrong");
	a_loop_tx_idle:
		assert property (loop_held |-> serial_out) else $error("serial out active in loopback");
	a_loop_pins_high:
		assert property (loop_held |-> terminal_ready_out_n && request_send_out_n) else $error("pins active in loop");
	a_txoff_idle:
		assert property (tx_off |-> serial_out) else $error("serial out low while disabled");
	a_ring_delta:
		assert property ($rose(ring_detect_in_n) && !MODEM_CONTROL_REG[MC_LOOP] |-> ##[1:5]
			MODEM_STATUS_REG[MS_TERI]) else $error("ring edge not reported");
	a_cts_status:
		assert property ($fell(clear_send_in_n) && !MODEM_CONTROL_REG[MC_LOOP] |-> ##[1:5]
			MODEM_STATUS_REG[MS_CTS]) else $error("cts not reported");
	a_irq_on_delta:
		assert property (MODEM_STATUS_REG[3:0] != 4'h0 |-> ##[0:1] MODEM_IRQ) else $error("modem irq missing");
endmodule : umlb_chk
bind umlb_channel umlb_chk umlb_chk_i (.CLK(CLK), .RST(RST), .MODEM_CONTROL_REG(MODEM_CONTROL_REG),
	.TX_ENABLE(TX_ENABLE), .clear_send_in_n(clear_send_in_n), .ring_detect_in_n(ring_detect_in_n),
	.serial_out(serial_out), .terminal_ready_out_n(terminal_ready_out_n), .request_send_out_n(request_send_out_n),
	.MODEM_STATUS_REG(MODEM_STATUS_REG), .RX_DATA_READY(RX_DATA_READY), .TX_SPACE(TX_SPACE), .MODEM_IRQ(MODEM_IRQ));

// ---- dv/umlb_channel_bench.sv ----
// Testbench: serial channel against the modem model
`timescale 1ns/1ps
module umlb_channel_bench
	import umlb_pkg::*;
;
	typedef struct packed {logic [4:0] lc; logic [7:0] d; logic bad;} umlb_row_t;
	logic CLK = 1'b0, RST = 1'b1, TX_ENABLE = 1'b1, TX_WR = 1'b0, RX_RD = 1'b0, MSR_RD = 1'b0;
	logic [7:0] MODEM_CONTROL_REG = 8'h00, TX_DATA = 8'h00, m, MODEM_STATUS_REG, RX_DATA;
	logic [4:0] LINE_CONTROL = 5'h03;
	logic [1:0] RX_TRIGGER_SEL = 2'h0;
	logic FIFO_ENABLE = 1'b1, RX_TRIGGER_IRQ;
	logic [11:0] f;
	logic serial_in, clear_send_in_n, set_ready_in_n, ring_detect_in_n, carrier_in_n, serial_out;
	logic terminal_ready_out_n, request_send_out_n, MODEM_IRQ, RX_DATA_READY, RX_PARITY_ERR, TX_SPACE;
	int n_mismatch = 0, comparisons = 0, cycles = 0, nb;
	umlb_row_t rows[4] = '{'{5'h03, 8'hA5, 1'b0}, '{5'h1B, 8'h3C, 1'b0}, '{5'h0A, 8'h55, 1'b1}, '{5'h0C, 8'h13, 1'b0}};
	always #50 CLK = ~CLK;
	umlb_channel umlb_channel_i (.CLK(CLK), .RST(RST), .MODEM_CONTROL_REG(MODEM_CONTROL_REG),
		.LINE_CONTROL(LINE_CONTROL), .RX_TRIGGER_SEL(RX_TRIGGER_SEL), .FIFO_ENABLE(FIFO_ENABLE), .TX_ENABLE(TX_ENABLE),
		.BAUD_DIV(16'h0001), .TX_WR(TX_WR), .TX_DATA(TX_DATA), .RX_RD(RX_RD), .MSR_RD(MSR_RD),
		.serial_in(serial_in), .clear_send_in_n(clear_send_in_n), .set_ready_in_n(set_ready_in_n),
		.ring_detect_in_n(ring_detect_in_n), .carrier_in_n(carrier_in_n), .serial_out(serial_out),
		.terminal_ready_out_n(terminal_ready_out_n), .request_send_out_n(request_send_out_n),
		.MODEM_STATUS_REG(MODEM_STATUS_REG), .RX_DATA(RX_DATA), .RX_DATA_READY(RX_DATA_READY),
		.RX_PARITY_ERR(RX_PARITY_ERR), .RX_FRAME_ERR(), .RX_OVERRUN(), .TX_SPACE(TX_SPACE),
		.RX_TRIGGER_IRQ(RX_TRIGGER_IRQ), .MODEM_IRQ(MODEM_IRQ));
	umlb_modem umlb_modem_i (.CLK(CLK), .serial_out(serial_out), .serial_in(serial_in),
		.clear_send_in_n(clear_send_in_n), .set_ready_in_n(set_ready_in_n),
		.ring_detect_in_n(ring_detect_in_n), .carrier_in_n(carrier_in_n));
	task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(negedge CLK);
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(2);
	endtask : pulse
	// Bounded so a dead receiver shows up as a data mismatch, not a hang
	task automatic wait_rx();
		for (int i = 0; i < 600 && RX_DATA_READY !== 1'b1; i++) tick(1);
		tick(2);
	endtask : wait_rx
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			complete_run();
		end
	end
	// ------
	// Main sequence
	// ------
	initial
	begin
		tick(5);
		RST = 1'b0;
		tick(1);
		check("serial_out", 12'h1, 12'(serial_out));
		check("dtr_rts", 12'h3, 12'({terminal_ready_out_n, request_send_out_n}));
		check("space_ready", 12'h2, 12'({TX_SPACE, RX_DATA_READY}));
		MODEM_CONTROL_REG = 8'h03;
		tick(2);
		check("dtr_rts", 12'h0, 12'({terminal_ready_out_n, request_send_out_n}));
		MODEM_CONTROL_REG = 8'h02;
		tick(2);
		check("dtr_rts", 12'h2, 12'({terminal_ready_out_n, request_send_out_n}));
		umlb_modem_i.set_lines(5'h1D);
		tick(6);
		pulse(MSR_RD);
		umlb_modem_i.set_lines(5'h13);
		tick(6);
		check("status", 12'h37, 12'(MODEM_STATUS_REG));
		check("modem_irq", 12'h1, 12'(MODEM_IRQ));
		pulse(MSR_RD);
		check("modem_irq", 12'h0, 12'(MODEM_IRQ));
		// Set-ready and clear-send stay low through reception
		foreach (rows[i])
		begin
			LINE_CONTROL = rows[i].lc;
			nb = rows[i].lc[1:0] + 5;
			m = rows[i].d & (8'hFF >> (8 - nb));
			tick(2);
			umlb_modem_i.send(m, nb, rows[i].lc[3], ^m ^ !rows[i].lc[4] ^ rows[i].bad, rows[i].lc[2] + 1);
			wait_rx();
			check("rx_data", 12'(m), 12'(RX_DATA));
			check("rx_parity", 12'(rows[i].bad), 12'(RX_PARITY_ERR));
			pulse(RX_RD);
		end
		LINE_CONTROL = 5'h1B;
		TX_DATA = 8'h96;
		fork
			pulse(TX_WR);
			umlb_modem_i.recv(11, f);
		join
		check("tx_frame", 12'({1'b1, ^8'h96, 8'h96, 1'b0}), f);
		MODEM_CONTROL_REG = 8'h19;
		tick(2);
		umlb_modem_i.set_lines(5'h03);
		LINE_CONTROL = 5'h03;
		tick(6);
		check("loop_pins", 12'h3, 12'({terminal_ready_out_n, request_send_out_n}));
		check("loop_status", 12'hA, 12'(MODEM_STATUS_REG[7:4]));
		TX_DATA = 8'hC3;
		RX_TRIGGER_SEL = 2'h1;
		pulse(TX_WR);
		wait_rx();
		check("loop_rx", 12'hC3, 12'(RX_DATA));
		check("rx_trig", 12'h0, 12'(RX_TRIGGER_IRQ));
		RX_TRIGGER_SEL = 2'h0;
		tick(2);
		check("rx_trig", 12'h1, 12'(RX_TRIGGER_IRQ));
		umlb_modem_i.set_lines(5'h13);
		MODEM_CONTROL_REG = 8'h00;
		TX_ENABLE = 1'b0;
		tick(4);
		check("serial_out", 12'h1, 12'(serial_out));
		complete_run();
	end
endmodule : umlb_channel_bench
